// >>> hdl/flash_fanout_pkg.sv
package flash_fanout_pkg;
  localparam int          addr_w        = 21;
  localparam int          data_w        = 16;
  localparam int          lane_w        = 8;
  localparam int          lanes         = 2;
  localparam logic [20:0] unlock1_addr  = 21'h000555;
  localparam logic [20:0] unlock2_addr  = 21'h0002aa;
  localparam logic [7:0]  unlock1_data  = 8'haa;
  localparam logic [7:0]  unlock2_data  = 8'h55;
  localparam logic [7:0]  program_cmd   = 8'ha0;
  localparam logic [7:0]  erase_cmd     = 8'h80;
  localparam logic [7:0]  sector_cfm    = 8'h30;
  localparam logic [7:0]  chip_cfm      = 8'h10;
  localparam int          polling_data_bit = 7;
  localparam int          clk_ns        = 50;
  // write pulse and high time, least figures
  localparam int          wp_ns         = 50;
  localparam int          wph_ns        = 20;
  localparam int          wp_cyc        = (wp_ns + clk_ns - 1) / clk_ns;
  localparam int          wph_cyc       = (wph_ns + clk_ns - 1) / clk_ns;
  localparam int          rd_ns         = 150;
  localparam int          rd_cyc        = (rd_ns + clk_ns - 1) / clk_ns;
  localparam logic [1:0]  op_program    = 2'h0;
  localparam logic [1:0]  op_sector     = 2'h1;
  localparam logic [1:0]  op_chip       = 2'h2;
endpackage : flash_fanout_pkg

// >>> hdl/flash_bus_cycle.sv
`timescale 1ns/1ps
// one write or read cycle on the flash pins
module flash_bus_cycle (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        start,
  input  wire logic        is_write,
  output logic             we_n,
  output logic             oe_n,
  output logic             sample,
  output logic             done
);
  logic [3:0] cnt;
  logic       busy;
  logic       phase;
  wire  [3:0] hi_len = 4'(flash_fanout_pkg::wph_cyc);
  wire  [3:0] lo_len = is_write ? 4'(flash_fanout_pkg::wp_cyc)
                                : 4'(flash_fanout_pkg::rd_cyc);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy   <= 1'b0;
      phase  <= 1'b0;
      cnt    <= 4'h0;
      we_n   <= 1'b1;
      oe_n   <= 1'b1;
      sample <= 1'b0;
      done   <= 1'b0;
    end else begin
      sample <= 1'b0;
      done   <= 1'b0;
      if (!busy && start) begin
        busy  <= 1'b1;
        phase <= 1'b0;
        cnt   <= lo_len;
        we_n  <= ~is_write;
        oe_n  <= is_write;
      end else if (busy && !phase) begin
        if (cnt == 4'h1) begin
          we_n   <= 1'b1;
          oe_n   <= 1'b1;
          sample <= oe_n == 1'b0;
          phase  <= 1'b1;
          cnt    <= hi_len;
        end else begin
          cnt <= cnt - 4'h1;
        end
      end else if (busy) begin
        // high time keeps the next write pulse apart
        if (cnt == 4'h1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt <= cnt - 4'h1;
        end
      end
    end
  end
endmodule : flash_bus_cycle

// >>> hdl/flash_fanout_host.sv
`timescale 1ns/1ps
// Behaviour
// - 8-bit commands repeated in both lanes
// - single-lane operation writes one device only
// - poll each busy lane separately
// - program ends A0 at 555, then data
// - erase uses 55 at 2AA, 30/10
module flash_fanout_host (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        op_valid,
  input  wire logic [1:0]  op_kind,
  input  wire logic [1:0]  op_lanes,
  input  wire logic [20:0] op_addr,
  input  wire logic [15:0] op_data,
  output logic             op_ready,
  output logic             op_done,
  output logic [1:0]       lane_busy,
  output logic [20:0]      flash_addr,
  output logic [15:0]      flash_dq_out,
  output logic             flash_dq_oe,
  input  wire logic [15:0] flash_dq_in,
  output logic [1:0]       flash_ce_n,
  output logic             flash_we_n,
  output logic             flash_oe_n,
  output logic             flash_reset_n
);
  typedef enum {st_idle, st_cmd, st_wait, st_poll, st_pwait} state_e;
  state_e      state;
  logic [2:0]  step;
  logic [1:0]  kind;
  logic [20:0] target;
  logic [15:0] value;
  logic [1:0]  pending;
  logic        lane_sel;
  logic [15:0] dq_meta;
  logic [15:0] dq_sync;
  logic [7:0]  poll_byte;
  logic        cyc_start;
  logic        cyc_write;
  logic        cyc_sample;
  logic        cyc_done;
  logic        we_n_c;
  logic        oe_n_c;

  // command addresses, declared ahead of the sequence table using them
  localparam logic [20:0] unlock1_a = flash_fanout_pkg::unlock1_addr;
  localparam logic [20:0] unlock2_a = flash_fanout_pkg::unlock2_addr;

  function automatic logic [28:0] seq_word(input logic [1:0] k,
      input logic [2:0] s, input logic [20:0] a, input logic [7:0] d);
    logic [28:0] w;
    w = {unlock1_a, flash_fanout_pkg::unlock1_data};
    unique case (s)
      3'h0: w = {unlock1_a, flash_fanout_pkg::unlock1_data};
      3'h1: w = {unlock2_a, flash_fanout_pkg::unlock2_data};
      3'h2: w = (k == flash_fanout_pkg::op_program)
              ? {unlock1_a, flash_fanout_pkg::program_cmd}
              : {unlock1_a, flash_fanout_pkg::erase_cmd};
      3'h3: w = (k == flash_fanout_pkg::op_program)
              ? {a, d} : {unlock1_a, flash_fanout_pkg::unlock1_data};
      3'h4: w = {unlock2_a, flash_fanout_pkg::unlock2_data};
      default: w = (k == flash_fanout_pkg::op_sector)
              ? {a, flash_fanout_pkg::sector_cfm}
              : {unlock1_a, flash_fanout_pkg::chip_cfm};
    endcase
    return w;
  endfunction : seq_word

  // chip enables that select one lane alone for a status read
  function automatic logic [1:0] lane_ce(input logic l);
    return ~(2'h1 << l);
  endfunction : lane_ce

  // per-lane byte; program data differs per lane, commands repeat
  wire [28:0] word_lo = seq_word(kind, step, target, value[7:0]);
  wire [28:0] word_hi = seq_word(kind, step, target, value[15:8]);
  wire [2:0]  last_step = (kind == flash_fanout_pkg::op_program)
                          ? 3'h3 : 3'h5;
  wire [7:0]  lane_rd = lane_sel ? dq_sync[15:8] : dq_sync[7:0];
  wire [7:0]  lane_wr = lane_sel ? value[15:8] : value[7:0];
  // program busy while bit 7 reads back inverted; erase busy until
  // the erased byte shows bit 7 set
  wire        still_busy = (poll_byte[flash_fanout_pkg::polling_data_bit]
                 != lane_wr[flash_fanout_pkg::polling_data_bit]);
  wire        erase_done = (poll_byte[flash_fanout_pkg::polling_data_bit]
                            == 1'b1);
  wire        lane_busy_now = (kind == flash_fanout_pkg::op_program)
                              ? still_busy : !erase_done;
  // finished lane leaves the pending set; lane 1 follows lane 0
  wire [1:0]  next_pending = pending & ~(2'h1 << lane_sel);
  wire        next_lane = next_pending[1] & ~next_pending[0];

  assign cyc_write = (state == st_cmd);
  assign cyc_start = (state == st_cmd) || (state == st_poll);

  flash_bus_cycle u_cycle (
    .clock    (clock),
    .nrst     (nrst),
    .start    (cyc_start),
    .is_write (cyc_write),
    .we_n     (we_n_c),
    .oe_n     (oe_n_c),
    .sample   (cyc_sample),
    .done     (cyc_done)
  );

  // pin data crosses in from outside the clock domain
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dq_meta <= 16'h0000;
      dq_sync <= 16'h0000;
    end else begin
      dq_meta <= flash_dq_in;
      dq_sync <= dq_meta;
    end
  end

  // status byte kept from inside the read strobe, before the lane
  // floats; judged only once the cycle timer reports done
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      poll_byte <= 8'h00;
    end else if (cyc_sample) begin
      poll_byte <= lane_rd;
    end
  end

  // strobes trail the cycle timer by a clock, so address, data and
  // chip enables are already steady when a strobe falls
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flash_we_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
      flash_reset_n <= 1'b0;
    end else begin
      flash_we_n    <= we_n_c;
      flash_oe_n    <= oe_n_c;
      flash_reset_n <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state         <= st_idle;
      step          <= 3'h0;
      kind          <= flash_fanout_pkg::op_program;
      target        <= 21'h000000;
      value         <= 16'h0000;
      pending       <= 2'h0;
      lane_sel      <= 1'b0;
      op_ready      <= 1'b0;
      op_done       <= 1'b0;
      lane_busy     <= 2'h0;
      flash_addr    <= 21'h000000;
      flash_dq_out  <= 16'h0000;
      flash_dq_oe   <= 1'b0;
      flash_ce_n    <= 2'h3;
    end else begin
      op_done       <= 1'b0;
      op_ready      <= (state == st_idle) && !op_valid;
      unique case (state)
        st_idle: begin
          if (op_valid && op_ready && op_lanes != 2'h0) begin
            kind      <= op_kind;
            target    <= op_addr;
            value     <= op_data;
            pending   <= op_lanes;
            lane_busy <= op_lanes;
            step      <= 3'h0;
            op_ready  <= 1'b0;
            flash_ce_n <= ~op_lanes; // only chosen lanes see writes
            state     <= st_cmd;
          end
        end
        st_cmd: begin
          flash_addr   <= word_lo[28:8];
          flash_dq_out <= {word_hi[7:0], word_lo[7:0]};
          flash_dq_oe  <= 1'b1;
          state        <= st_wait;
        end
        st_wait: begin
          if (cyc_done) begin
            if (step == last_step) begin // starts on last write
              flash_dq_oe <= 1'b0;
              // low lane is read first whenever it took part
              lane_sel    <= ~pending[0];
              flash_ce_n  <= lane_ce(~pending[0]);
              state       <= st_poll;
            end else begin
              step  <= step + 3'h1;
              state <= st_cmd;
            end
          end
        end
        st_poll: begin
          // read at target so program status is valid
          flash_addr <= target;
          state      <= st_pwait;
        end
        st_pwait: begin
          if (cyc_done) begin
            if (lane_busy_now) begin
              state <= st_poll; // this lane alone decides
            end else begin
              lane_busy[lane_sel] <= 1'b0;
              pending             <= next_pending;
              if (next_pending == 2'h0) begin
                flash_ce_n <= 2'h3;
                op_done    <= 1'b1;
                state      <= st_idle;
              end else begin
                lane_sel   <= next_lane;
                flash_ce_n <= lane_ce(next_lane);
                state      <= st_poll;
              end
            end
          end
        end
      endcase
    end
  end
endmodule : flash_fanout_host

// >>> test/flash_fanout_host_chk.sv
`timescale 1ns/1ps
module flash_fanout_host_chk (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic [1:0]  lane_busy,
  input wire logic [20:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic [1:0]  flash_ce_n,
  input wire logic        flash_we_n,
  input wire logic        flash_oe_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // byte of the selected lane, low lane when both
  wire [7:0] cmd = flash_ce_n[0] ? flash_dq_out[15:8] : flash_dq_out[7:0];
  wire       wr  = !flash_we_n;
  sequence put(logic [7:0] v);
    wr && cmd == v;
  endsequence
  sequence confirm;
    wr && (cmd == 8'h30 || cmd == 8'h10 && flash_addr == 21'h555);
  endsequence
  AST_LANE_COPY:
    assert property (wr && flash_ce_n == 2'h0 && flash_addr == 21'h2aa
      |-> flash_dq_out == 16'h5555) else $error("lanes differ");
  AST_ONE_LANE:
    assert property (lane_busy != 2'h0 |-> (flash_ce_n | lane_busy) == 2'h3)
      else $error("idle lane selected");
  AST_POLL_ONE:
    assert property (!flash_oe_n |-> $onehot(~flash_ce_n))
      else $error("poll not per lane");
  // command writes land every fourth clock; the unlock byte ahead keeps
  // program data that happens to equal a0 or 80 out of the antecedent
  AST_PROGRAM:
    assert property (put(8'h55) ##4 put(8'ha0)
      |-> flash_addr == 21'h555 ##4 wr ##1 !wr)
      else $error("program tail wrong");
  AST_ERASE:
    assert property (put(8'h55) ##4 put(8'h80)
      |-> ##4 put(8'haa) ##4 put(8'h55) ##4 confirm)
      else $error("erase tail wrong");
endmodule : flash_fanout_host_chk

// >>> test/flash_model.sv
`timescale 1ns/1ps
module flash_model (
  input  wire logic        clock,
  input  wire logic        flash_reset_n,
  input  wire logic [1:0]  flash_ce_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic [3:0]  slow,
  output logic      [15:0] flash_dq_in
);
  logic [7:0] prev [2];
  logic [7:0] pd   [2];
  logic [7:0] st   [2];
  logic [3:0] busy [2];
  logic       arm  [2];
  // each byte device keeps its own state
  always @(posedge clock) begin
    for (int i = 0; i < 2; i++) begin
      if (!flash_reset_n) begin
        prev[i] <= 8'h00;
        busy[i] <= 4'h0;
        arm[i]  <= 1'b0;
        pd[i]   <= 8'hff;
      end else if (!flash_we_n && !flash_ce_n[i]) begin
        prev[i] <= flash_dq_out[8*i +: 8];
        if (prev[i] == 8'ha0) begin
          pd[i]   <= flash_dq_out[8*i +: 8];
          busy[i] <= slow;
          // data byte a0 must not arm a second program
          prev[i] <= 8'h00;
        end
        if (flash_dq_out[8*i +: 8] == 8'h80) arm[i] <= 1'b1;
        // 10 and 30 both pass the or-mask
        if (arm[i] && prev[i] == 8'h55
            && (flash_dq_out[8*i +: 8] | 8'h20) == 8'h30) begin
          pd[i]   <= 8'hff;
          busy[i] <= slow;
          arm[i]  <= 1'b0;
        end
      end else if (!flash_oe_n && !flash_ce_n[i] && busy[i] != 4'h0) begin
        busy[i] <= busy[i] - 4'h1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      st[i] = busy[i] != 4'h0 ? {~pd[i][7], pd[i][6:0]} : pd[i];
      // deselected lane shows inverse, never a stale match
      flash_dq_in[8*i +: 8] = !flash_oe_n && !flash_ce_n[i] ? st[i] : ~st[i];
    end
  end
endmodule : flash_model

// >>> test/flash_fanout_host_test.sv
`timescale 1ns/1ps
module flash_fanout_host_test;
  logic        clock    = 1'b0;
  logic        nrst     = 1'b0;
  logic        op_valid = 1'b0;
  logic [1:0]  op_kind  = 2'h0;
  logic [1:0]  op_lanes = 2'h0;
  logic [20:0] op_addr  = 21'h0;
  logic [15:0] op_data  = 16'h0;
  logic [3:0]  slow     = 4'h0;
  logic        op_ready, op_done, flash_dq_oe, flash_we_n, flash_oe_n;
  logic        flash_reset_n;
  logic [1:0]  lane_busy, flash_ce_n, k, l;
  logic [20:0] flash_addr, a;
  logic [15:0] flash_dq_out, flash_dq_in, dev_dq, d;
  logic [7:0]  last_d [2];
  logic [20:0] last_a [2];
  int          n_fail = 0, checks_done = 0, seed = 67, n_wr [2], n_rd [2];
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : dev_dq;
  always #25 clock = ~clock;
  flash_fanout_host dut (.*);
  flash_model dev (.*, .flash_dq_in(dev_dq));
  always @(posedge clock) begin
    for (int i = 0; i < 2; i++) begin
      if (!flash_ce_n[i] && !flash_we_n) begin
        n_wr[i]++;
        last_d[i] <= flash_dq_out[8*i +: 8];
        last_a[i] <= flash_addr;
      end
      if (!flash_ce_n[i] && !flash_oe_n) n_rd[i]++;
    end
  end
  task check(input string name, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  task run_op(input logic [3:0] s);
    int t;
    t = 0;
    while (op_ready !== 1'b1 && t < 100) begin
      @(posedge clock);
      #1 t++;
    end
    @(posedge clock);
    n_wr = '{0, 0};
    n_rd = '{0, 0};
    op_valid <= 1'b1;
    op_kind  <= k;
    op_lanes <= l;
    op_addr  <= a;
    op_data  <= d;
    slow     <= s;
    @(posedge clock);
    op_valid <= 1'b0;
    #1 check("lanes busy", lane_busy, l);
    t = 0;
    // refused request: short wait, no pulse due
    while (op_done !== 1'b1 && t < (l != 2'h0 ? 3000 : 40)) begin
      @(posedge clock);
      #1 t++;
    end
    check("done", op_done, l != 2'h0);
    check("released", {flash_reset_n, lane_busy, flash_ce_n, flash_dq_oe},
      6'h26);
    for (int i = 0; i < 2; i++) begin
      check("writes", n_wr[i], !l[i] ? 0 : k == 2'h0 ? 4 : 6);
      check("reads", l[i] ? n_rd[i] >= (s ? s : 1) : n_rd[i] == 0, 1);
      if (l[i]) begin
        check("data", last_d[i], k == 2'h0 ? d[8*i +: 8]
          : k == 2'h1 ? 8'h30 : 8'h10);
        check("addr", last_a[i], k == 2'h2 ? 21'h555 : a);
      end
    end
  endtask : run_op
  initial begin
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    for (int n = 0; n < 24; n++) begin
      k = n < 3 ? n[1:0] : 2'({$random(seed)} % 3);
      l = n < 4 ? 2'(n + 1) : 2'($random(seed));
      // keeps program targets off the command addresses
      a = (21'($random(seed)) & 21'h1ff000) | 21'h100;
      d = 16'($random(seed)) | 16'h0101;
      run_op(4'({$random(seed)} % 9));
    end
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    finish_test;
  end
endmodule : flash_fanout_host_test
bind flash_fanout_host flash_fanout_host_chk chk (.clock, .nrst, .lane_busy,
  .flash_addr, .flash_dq_out, .flash_ce_n, .flash_we_n, .flash_oe_n);
